// File: dv/analog_model.sv
// Analog side model: crystal, wake measurement, depth detector.
// Assumes the block's outputs and the bench clock; answers after dly.
`timescale 1ns/1ns
module analog_model (
  // Clock and bench controls
  input  wire logic       clk_sys_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] wake_val_i,
  // Requests from the block
  input  wire logic       osc_on_i,
  input  wire logic       meas_start_i,
  input  wire logic       depth_req_i,
  input  wire logic [7:0] am_level_i,
  // Answers to the block
  output logic            osc_stable_o,
  output logic            meas_done_o,
  output logic [7:0]      meas_value_o,
  output logic            depth_valid_o,
  output logic [7:0]      depth_meas_o
);
  int         osc_cnt = 0;
  int         wait_m = -1;
  int         wait_d = -1;
  int         dly;
  logic [7:0] lvl = 8'h00;
  // Slow answers land on the same edge as the next wake tick
  assign dly = slow_i ? 6 : 1;
  //////////////////////////////////////////
  // Quiet start of every answer line
  initial begin
    osc_stable_o = 1'b0;
    meas_done_o = 1'b0;
    depth_valid_o = 1'b0;
    meas_value_o = 8'h00;
    depth_meas_o = 8'h00;
  end
  // Crystal settles; strobed answers; idle data lines keep moving
  always @(posedge clk_sys_i) begin
    osc_cnt <= osc_on_i ? osc_cnt + 1 : 0;
    osc_stable_o <= osc_on_i && osc_cnt >= 4;
    meas_done_o <= 1'b0;
    depth_valid_o <= 1'b0;
    meas_value_o <= ~meas_value_o;
    depth_meas_o <= ~depth_meas_o;
    wait_m <= meas_start_i ? dly : wait_m - 1;
    wait_d <= depth_req_i ? dly : wait_d - 1;
    if (depth_req_i) begin
      lvl <= am_level_i;
    end
    if (wait_m == 0) begin
      meas_done_o <= 1'b1;
      meas_value_o <= wake_val_i;
    end
    if (wait_d == 0) begin
      depth_valid_o <= 1'b1;
      depth_meas_o <= lvl;
    end
  end
endmodule

// File: dv/tb_top.sv
// Bench for the front end mode control, with expected values worked out inline.
// Assumes the analog model answers oscillator, wake and depth requests.
`timescale 1ns/1ns
module tb_top import rf_mode_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_i, op_wr_i, norm_wr_i, cal_cmd_i, mask_start_i, mask_cmd_i;
  logic unmask_cmd_i, osc_flag_clr_i, wake_flag_clr_i, mod_i, rx_digit_i;
  logic framing_pick_pm_i, slow, osc_stable_i, meas_done_i, depth_valid_i;
  op_ctrl_t    op_data_i, op_ctrl_o;
  tx_cfg_t     tx_cfg_i;
  rx_cfg_t     rx_cfg_i;
  mode_t       mode_o;
  logic [7:0]  norm_data_i, depth_target_i, wake_ref_i, wake_thresh_i;
  logic [7:0]  meas_value_i, depth_meas_i, wval, am_level_o;
  logic [7:0]  driver_out_a_seg_o, driver_out_b_seg_o;
  logic [15:0] mask_len_i;
  logic osc_on_o, rc_osc_on_o, meas_start_o, irq_o, osc_flag_o, wake_flag_o;
  logic driver_out_a_oe_o, driver_out_b_oe_o, cal_busy_o, depth_req_o;
  logic supply_collapse_o, rx_power_o, am_chan_on_o, pm_chan_on_o;
  logic use_pm_o, rx_on_o, rssi_agc_en_o, rx_data_o, mixer_sel_o;
  logic demod_bypass_o;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [31:0] rs = 32'h0001_2531;
  // Short wake period keeps the run brief
  rf_frontend_mode_control #(.WAKE_PERIOD(8)) dut (
    .clk_sys_i, .rst_i, .op_wr_i, .op_data_i, .tx_cfg_i, .rx_cfg_i,
    .norm_wr_i, .norm_data_i, .depth_target_i, .wake_ref_i, .wake_thresh_i,
    .mask_len_i, .cal_cmd_i, .mask_start_i, .mask_cmd_i, .unmask_cmd_i,
    .osc_flag_clr_i, .wake_flag_clr_i, .osc_stable_i, .meas_done_i,
    .meas_value_i, .depth_valid_i, .depth_meas_i, .mod_i, .rx_digit_i,
    .framing_pick_pm_i, .op_ctrl_o, .mode_o, .osc_on_o, .rc_osc_on_o,
    .meas_start_o, .irq_o, .osc_flag_o, .wake_flag_o, .driver_out_a_seg_o,
    .driver_out_b_seg_o, .driver_out_a_oe_o, .driver_out_b_oe_o,
    .am_level_o, .cal_busy_o, .depth_req_o, .supply_collapse_o,
    .rx_power_o, .am_chan_on_o, .pm_chan_on_o, .use_pm_o, .rx_on_o,
    .rssi_agc_en_o, .rx_data_o, .mixer_sel_o, .demod_bypass_o
  );
  analog_model partner (
    .clk_sys_i, .slow_i(slow), .wake_val_i(wval), .osc_on_i(osc_on_o),
    .meas_start_i(meas_start_o), .depth_req_i(depth_req_o),
    .am_level_i(am_level_o), .osc_stable_o(osc_stable_i),
    .meas_done_o(meas_done_i), .meas_value_o(meas_value_i),
    .depth_valid_o(depth_valid_i), .depth_meas_o(depth_meas_i)
  );
  //////////////////////////////////////////
  // Clock, cycle count and hang guard
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  // Xorshift source for stimulus
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic nc(input int n = 1);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    nc();
    s = 1'b0;
  endtask
  // Word lands one edge later, mode one more
  task automatic wr_op(input logic [7:0] v);
    op_data_i = v;
    pulse(op_wr_i);
    chk(op_ctrl_o, v);
    nc();
  endtask
  // Receive gating follows the expected receive window
  task automatic rxc(input int n, input logic on);
    logic [7:0] r;
    repeat (n) begin
      r = rnd();
      rx_digit_i = r[0];
      nc();
      chk({rx_on_o, rssi_agc_en_o, rx_data_o}, {on, on, on & r[0]});
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////
  // Main sequence
  initial begin
    int k;
    int last;
    logic [7:0] a, nv, v;
    logic e, on_a, on_b;
    logic [7:0] wv [4];
    wv = '{8'h90, 8'h91, 8'h6F, 8'h70};
    {op_wr_i, norm_wr_i, cal_cmd_i, mask_start_i, mask_cmd_i} = '0;
    {unmask_cmd_i, osc_flag_clr_i, wake_flag_clr_i, mod_i, slow} = '0;
    {rx_digit_i, framing_pick_pm_i, tx_cfg_i, rx_cfg_i} = '0;
    {op_data_i, norm_data_i, depth_target_i, wval} = '0;
    wake_ref_i = 8'h80;
    wake_thresh_i = 8'h10;
    mask_len_i = 16'h0000;
    rst_i = 1'b1;
    nc(8);
    rst_i = 1'b0;
    chk(op_ctrl_o, 8'h00);
    chk(mode_o, MODE_DOWN);
    chk({osc_on_o, driver_out_a_oe_o, rx_on_o, am_level_o}, 11'h000);
    wr_op(8'h40);
    chk({mode_o, rx_power_o, driver_out_a_oe_o}, {MODE_DOWN, 2'b10});
    wr_op(8'h80);
    chk({mode_o, osc_on_o}, {MODE_READY, 1'b1});
    for (k = 0; k < 30 && !osc_stable_i; k++) nc();
    nc();
    chk({irq_o, osc_flag_o}, 2'b11);
    nc();
    chk({irq_o, osc_flag_o}, 2'b01);
    pulse(osc_flag_clr_i);
    chk(osc_flag_o, 1'b0);
    wr_op(8'h88);
    nc(2);
    chk({driver_out_a_seg_o, driver_out_b_seg_o}, 16'hFFFF);
    nv = rnd();
    norm_data_i = nv;
    pulse(norm_wr_i);
    // Depth search, prompt then slow answers
    for (k = 0; k < 2; k++) begin
      slow = k[0];
      depth_target_i = rnd();
      pulse(cal_cmd_i);
      for (last = 0; last < 300 && cal_busy_o; last++) nc();
      a = 8'h00;
      for (int b = 7; b >= 0; b--) begin
        if ((a | (8'h01 << b)) >= depth_target_i) a = a | (8'h01 << b);
      end
      chk(am_level_o, a);
    end
    // Every driver setting with and without modulation
    for (k = 0; k < 32; k++) begin
      tx_cfg_i = tx_cfg_t'({k[3:0], 1'b0});
      mod_i = k[4];
      nc(2);
      v = !mod_i ? nv : (k[1] ? a & nv : 8'h00);
      e = !(mod_i && !k[1] && k[0]);
      on_a = !k[3] || !k[2];
      on_b = !k[3] || k[2];
      chk(driver_out_a_seg_o, on_a ? v : 8'h00);
      chk(driver_out_b_seg_o, on_b ? v : 8'h00);
      chk({driver_out_a_oe_o, driver_out_b_oe_o}, {on_a & e, on_b & e});
    end
    tx_cfg_i = '0;
    mod_i = 1'b0;
    wr_op(8'h80);
    tx_cfg_i.slow_up = 1'b1;
    nc();
    chk(supply_collapse_o, 1'b1);
    wr_op(8'h88);
    chk(supply_collapse_o, 1'b0);
    tx_cfg_i.slow_up = 1'b0;
    // Channel, demodulator and bypass choices
    for (k = 0; k < 32; k++) begin
      framing_pick_pm_i = k[3];
      rx_cfg_i = {k[4], !k[4], k[2]};
      wr_op({2'b11, k[0], k[1], 4'h0});
      e = k[0] ? k[2] : (k[1] ? k[2] : k[3]);
      v = {4'h0, 1'b1, !k[0] || !k[2], !k[0] || k[2], e};
      chk({rx_power_o, am_chan_on_o, pm_chan_on_o, use_pm_o}, v[3:0]);
      chk({mixer_sel_o, demod_bypass_o}, {k[4], !k[4]});
    end
    // Receive window: commands and mask timer
    mask_len_i = 16'(3 + rnd() % 8);
    pulse(unmask_cmd_i);
    rxc(2, 1'b1);
    pulse(mask_start_i);
    rxc(int'(mask_len_i), 1'b0);
    nc();
    chk(rx_on_o, 1'b1);
    rxc(2, 1'b1);
    mask_cmd_i = 1'b1;
    pulse(unmask_cmd_i);
    mask_cmd_i = 1'b0;
    rxc(3, 1'b0);
    // Wake mode: tick spacing and threshold edges
    wr_op(8'h04);
    chk({mode_o, rc_osc_on_o}, {MODE_WAKE, 1'b1});
    for (k = 0; k < 5; k++) begin
      wval = (k == 4) ? rnd() : wv[k];
      for (int i = 0; i < 20 && !meas_done_i; i++) nc();
      if (k > 0) chk(16'(cyc - last), 16'h0008);
      last = cyc;
      nc();
      e = (wval > 8'h80 ? wval - 8'h80 : 8'h80 - wval) > 8'h10;
      chk({irq_o, wake_flag_o}, {e, e});
      pulse(wake_flag_clr_i);
    end
    wr_op(8'h0C);
    chk(mode_o, MODE_DOWN);
    final_report();
  end
endmodule

// File: logic/rf_frontend_mode_control.sv
// Mode, transmitter and receiver control of an HF reader front end.
// Assumes host settings arrive as plain synchronous ports and that the
// analog side reports oscillator, measurement and depth results.
`timescale 1ns/1ns

// How it works
// R1: Reset clears the operation control word; device sits in power-down.
// R2: Settings ports accept writes in every mode, power-down included.
// R3: Oscillator enable bit turns on crystal and regulators: ready mode.
// R4: In ready mode, stable oscillator raises one interrupt pulse.
// R5: Receiver and transmitter enables act independently.
// R6: Only low-power bit set selects wake mode with periodic measurements.
// R7: Wake measurement differing from reference raises an interrupt; the code raises it only when the distance exceeds wake_thresh_i.
// R8: Single-drive bit leaves only one driver running.
// R9: Eight weighted segments; normal level register defaults to all on.
// R10: In single mode the antenna choice bit picks the active output.
// R11: Modulation type bit picks AM or on-off keying.
// R12: Keying stops carrier; fast decay tristates drivers instead.
// R13: AM modulation uses the smaller modulated segment set.
// R14: Depth calibration command searches the AM level for target depth.
// R15: Host holds slow ramp 2 ms with transmitter off before enabling.
// R16: Receiver powered while receiver enable bit is set.
// R17: Channel bits pick AM, PM or both, and auto or manual choice.
// R18: Receive-expected gates RSSI, AGC and data passed to framing.
// R19: Mask timer expiry raises receive-expected; commands force it.
// R20: Demodulator bit picks peak follower or synchronous mixer.
// R21: Host picks mixer for fast subcarriers.
// R22: Bypass bit routes receiver inputs past the demodulators.
// R23: Oscillator and wake events set separate sticky status flags.
module rf_frontend_mode_control import rf_mode_pkg::*; #(
  parameter int unsigned WAKE_PERIOD = WAKE_PERIOD_CYC,
  parameter int unsigned MASK_W      = 16
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Host settings
  input  wire logic              op_wr_i,
  input  wire op_ctrl_t          op_data_i,
  input  wire tx_cfg_t           tx_cfg_i,
  input  wire rx_cfg_t           rx_cfg_i,
  input  wire logic              norm_wr_i,
  input  wire logic [7:0]        norm_data_i,
  input  wire logic [7:0]        depth_target_i,
  input  wire logic [7:0]        wake_ref_i,
  input  wire logic [7:0]        wake_thresh_i,
  input  wire logic [MASK_W-1:0] mask_len_i,
  // Host commands, one-cycle pulses
  input  wire logic              cal_cmd_i,
  input  wire logic              mask_start_i,
  input  wire logic              mask_cmd_i,
  input  wire logic              unmask_cmd_i,
  input  wire logic              osc_flag_clr_i,
  input  wire logic              wake_flag_clr_i,
  // Analog and framing side
  input  wire logic              osc_stable_i,
  input  wire logic              meas_done_i,
  input  wire logic [7:0]        meas_value_i,
  input  wire logic              depth_valid_i,
  input  wire logic [7:0]        depth_meas_i,
  input  wire logic              mod_i,
  input  wire logic              rx_digit_i,
  input  wire logic              framing_pick_pm_i,
  // Power and mode
  output op_ctrl_t               op_ctrl_o,
  output mode_t                  mode_o,
  output logic                   osc_on_o,
  output logic                   rc_osc_on_o,
  output logic                   meas_start_o,
  output logic                   irq_o,
  output logic                   osc_flag_o,
  output logic                   wake_flag_o,
  // Transmitter
  output logic [SEG_COUNT-1:0]   driver_out_a_seg_o,
  output logic [SEG_COUNT-1:0]   driver_out_b_seg_o,
  output logic                   driver_out_a_oe_o,
  output logic                   driver_out_b_oe_o,
  output logic [7:0]             am_level_o,
  output logic                   cal_busy_o,
  output logic                   depth_req_o,
  output logic                   supply_collapse_o,
  // Receiver
  output logic                   rx_power_o,
  output logic                   am_chan_on_o,
  output logic                   pm_chan_on_o,
  output logic                   use_pm_o,
  output logic                   rx_on_o,
  output logic                   rssi_agc_en_o,
  output logic                   rx_data_o,
  output logic                   mixer_sel_o,
  output logic                   demod_bypass_o
);

  // Refused at elaboration: counter width must lie between 1 and 32 bits
  if (MASK_W < 1 || MASK_W > 32) begin
    $error("MASK_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings storage

  op_ctrl_t   op_ctrl;
  logic [7:0] norm_level;

  // Ports stay live in every mode so setup can precede power-up
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_ctrl    <= op_ctrl_t'(OP_RESET);      // R1
      norm_level <= NORM_RESET;                // R9
    end else begin
      if (op_wr_i) op_ctrl <= op_data_i;       // R2
      if (norm_wr_i) norm_level <= norm_data_i; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode

  mode_t mode;
  mode_t next_mode;
  wire   only_wu = op_ctrl.low_power_detect_mode && !op_ctrl.osc_en &&
                   !op_ctrl.rx_en && !op_ctrl.rx_chn && !op_ctrl.rx_man &&
                   !op_ctrl.tx_en && (op_ctrl.spare == 2'b00);

  assign next_mode = op_ctrl.osc_en ? MODE_READY :  // R3
                     only_wu        ? MODE_WAKE  :  // R6
                                      MODE_DOWN;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) mode <= MODE_DOWN;              // R1
    else       mode <= next_mode;
  end

  wire in_ready = (mode == MODE_READY);
  wire in_wake  = (mode == MODE_WAKE);

  ////////////////////////////////////////////////////////////////////////
  // Oscillator stable and wake detection events

  logic stable_seen;
  logic wake_hit;
  logic [7:0] diff;

  // Absolute distance from the stored reference
  assign diff = (meas_value_i > wake_ref_i) ? meas_value_i - wake_ref_i
                                            : wake_ref_i - meas_value_i;
  assign wake_hit = in_wake && meas_done_i && (diff > wake_thresh_i); // R7

  wire osc_evt = in_ready && osc_stable_i && !stable_seen; // R4

  // One event per ready entry; leaving ready rearms it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !in_ready) stable_seen <= 1'b0;
    else if (osc_stable_i)  stable_seen <= 1'b1;
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      osc_flag_o  <= 1'b0;
      wake_flag_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      osc_flag_o  <= osc_evt  | (osc_flag_o  & ~osc_flag_clr_i);  // R23
      wake_flag_o <= wake_hit | (wake_flag_o & ~wake_flag_clr_i); // R23
      irq_o       <= osc_evt | wake_hit;                           // R4 R7
    end
  end

  wake_tick #(
    .PERIOD (WAKE_PERIOD)
  ) u_wake (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .run_i     (in_wake),
    .tick_o    (meas_start_o)                  // R6
  );

  assign op_ctrl_o   = op_ctrl;
  assign mode_o      = mode;
  assign osc_on_o    = in_ready;               // R3
  assign rc_osc_on_o = in_wake;                // R6

  ////////////////////////////////////////////////////////////////////////
  // Depth calibration: binary search, one bit per measurement

  cal_state_t cal_state;
  logic [7:0] am_level;
  logic [7:0] trial_bit;
  wire        cal_go  = cal_cmd_i && cal_state == CAL_IDLE;
  wire        keep_it = depth_meas_i >= depth_target_i;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cal_state <= CAL_IDLE;
      am_level  <= AM_RESET;
      trial_bit <= 8'h00;
    end else begin
      unique case (cal_state)
        CAL_IDLE: begin
          if (cal_go) begin                    // R14
            am_level  <= 8'h80;
            trial_bit <= 8'h80;
            cal_state <= CAL_MEAS;
          end
        end
        CAL_MEAS: cal_state <= CAL_WAIT;
        CAL_WAIT: begin
          if (depth_valid_i) begin             // R14
            am_level  <= (keep_it ? am_level : am_level & ~trial_bit) |
                         (trial_bit >> 1);
            trial_bit <= trial_bit >> 1;
            cal_state <= (trial_bit == 8'h01) ? CAL_IDLE : CAL_MEAS;
          end
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  assign am_level_o  = am_level;
  assign cal_busy_o  = (cal_state != CAL_IDLE);
  assign depth_req_o = (cal_state == CAL_MEAS);

  ////////////////////////////////////////////////////////////////////////
  // Driver segments and enables

  wire        tx_on = op_ctrl.tx_en && in_ready;    // R5
  wire        keying = !tx_cfg_i.modulation_type_select; // R11
  wire [7:0]  seg_mod = keying ? 8'h00 : (am_level & norm_level); // R12 R13
  wire [7:0]  seg_sel = !tx_on ? 8'h00 : mod_i ? seg_mod : norm_level; // R9
  wire        tristate = tx_on && mod_i && keying &&
                         tx_cfg_i.keying_fast_decay; // R12
  wire        use_a = !tx_cfg_i.single_drive ||
                      !tx_cfg_i.antenna_output_choice; // R8 R10
  wire        use_b = !tx_cfg_i.single_drive ||
                      tx_cfg_i.antenna_output_choice;  // R8 R10

  // Registered so segment lines never glitch on setting changes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      driver_out_a_seg_o <= '0;
      driver_out_b_seg_o <= '0;
      driver_out_a_oe_o  <= 1'b0;
      driver_out_b_oe_o  <= 1'b0;
    end else begin
      driver_out_a_seg_o <= use_a ? seg_sel : 8'h00;
      driver_out_b_seg_o <= use_b ? seg_sel : 8'h00;
      driver_out_a_oe_o  <= use_a && tx_on && !tristate;
      driver_out_b_oe_o  <= use_b && tx_on && !tristate;
    end
  end

  // Driver rail collapses while ramp mode waits with transmitter off
  assign supply_collapse_o = tx_cfg_i.slow_up && !op_ctrl.tx_en; // R15

  ////////////////////////////////////////////////////////////////////////
  // Receiver channels and demodulator selection

  assign rx_power_o     = op_ctrl.rx_en;       // R16 R5
  assign am_chan_on_o   = rx_power_o && (!op_ctrl.rx_chn ||
                          !rx_cfg_i.pm_manual_pick); // R17
  assign pm_chan_on_o   = rx_power_o && (!op_ctrl.rx_chn ||
                          rx_cfg_i.pm_manual_pick);  // R17
  assign mixer_sel_o    = rx_cfg_i.amd_mixer;          // R20
  assign demod_bypass_o = rx_cfg_i.external_demod_bypass; // R22

  // Auto pick only when both channels run and manual mode is off
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) use_pm_o <= 1'b0;
    else if (op_ctrl.rx_chn) use_pm_o <= rx_cfg_i.pm_manual_pick; // R17
    else if (op_ctrl.rx_man) use_pm_o <= rx_cfg_i.pm_manual_pick;
    else use_pm_o <= framing_pick_pm_i;                // R17
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive mask timer and receive-expected level

  logic [MASK_W-1:0] mask_cnt;
  logic              mask_run;
  logic              rx_on;
  wire               mask_end = mask_run && (mask_cnt == '0);

  // Commands take priority over the timer; a zero length expires at once
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask_cnt <= '0;
      mask_run <= 1'b0;
      rx_on    <= 1'b0;
    end else if (mask_cmd_i) begin
      mask_run <= 1'b0;
      rx_on    <= 1'b0;                        // R19
    end else if (unmask_cmd_i) begin
      mask_run <= 1'b0;
      rx_on    <= 1'b1;                        // R19
    end else if (mask_start_i) begin
      mask_cnt <= mask_len_i;
      mask_run <= 1'b1;
      rx_on    <= 1'b0;
    end else if (mask_end) begin
      mask_run <= 1'b0;
      rx_on    <= 1'b1;                        // R19
    end else if (mask_run) begin
      mask_cnt <= mask_cnt - 1'b1;
    end
  end

  assign rx_on_o       = rx_on;
  assign rssi_agc_en_o = rx_on && rx_power_o;  // R18
  assign rx_data_o     = rx_on && rx_power_o && rx_digit_i; // R18

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_cal_step;
    cal_state == CAL_MEAS ##1 cal_state == CAL_WAIT;
  endsequence

  property p_reset_down;
    @(posedge clk_sys_i) rst_i |=> mode == MODE_DOWN && op_ctrl == '0;
  endproperty
  a_reset_down: assert property (p_reset_down) // R1
    else $error("reset did not clear mode");

  property p_write_in_down;
    @(posedge clk_sys_i) disable iff (rst_i)
      op_wr_i && mode == MODE_DOWN |=> op_ctrl == $past(op_data_i);
  endproperty
  a_write_in_down: assert property (p_write_in_down) // R2
    else $error("write lost in power-down");

  property p_ready;
    @(posedge clk_sys_i) disable iff (rst_i)
      op_ctrl.osc_en |=> mode == MODE_READY && osc_on_o;
  endproperty
  a_ready: assert property (p_ready) // R3
    else $error("ready mode not entered");

  property p_osc_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      in_ready && osc_stable_i && !stable_seen |=> irq_o && osc_flag_o;
  endproperty
  a_osc_irq: assert property (p_osc_irq) // R4
    else $error("stable oscillator gave no interrupt");

  property p_wake_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      wake_hit |=> irq_o && wake_flag_o;
  endproperty
  a_wake_irq: assert property (p_wake_irq) // R7
    else $error("wake difference gave no interrupt");

  property p_flag_sticky;
    @(posedge clk_sys_i) disable iff (rst_i)
      osc_flag_o && !osc_flag_clr_i |=> osc_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R23
    else $error("status flag dropped without clear");

  property p_single;
    @(posedge clk_sys_i) disable iff (rst_i)
      tx_cfg_i.single_drive |=> !(driver_out_a_oe_o && driver_out_b_oe_o);
  endproperty
  a_single: assert property (p_single) // R8
    else $error("both drivers on in single mode");

  property p_fast_decay;
    @(posedge clk_sys_i) disable iff (rst_i)
      tristate |=> !driver_out_a_oe_o && !driver_out_b_oe_o;
  endproperty
  a_fast_decay: assert property (p_fast_decay) // R12
    else $error("drivers not released in fast decay");

  property p_cal_bound;
    @(posedge clk_sys_i) disable iff (rst_i)
      cal_go |=> s_cal_step;
  endproperty
  a_cal_bound: assert property (p_cal_bound) // R14
    else $error("calibration did not start a measurement");

  property p_gate;
    @(posedge clk_sys_i) disable iff (rst_i)
      !rx_on_o |-> !rx_data_o && !rssi_agc_en_o;
  endproperty
  a_gate: assert property (p_gate) // R18
    else $error("receiver output passed while masked");

  property p_unmask;
    @(posedge clk_sys_i) disable iff (rst_i)
      unmask_cmd_i && !mask_cmd_i |=> rx_on_o;
  endproperty
  a_unmask: assert property (p_unmask) // R19
    else $error("unmask did not raise receive-expected");

endmodule

// File: logic/rf_mode_pkg.sv
// Package for the reader front end mode control block.
// Assumes a single 250 MHz system clock and a synchronous reset.
package rf_mode_pkg;

  // Clock rate and derived periods
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned WAKE_PERIOD_US = 100;
  localparam int unsigned WAKE_PERIOD_CYC = WAKE_PERIOD_US * CLK_MHZ;

  // Operation control field positions
  localparam int unsigned OP_EN_BIT     = 7;
  localparam int unsigned OP_RX_EN_BIT  = 6;
  localparam int unsigned OP_RX_CHN_BIT = 5;
  localparam int unsigned OP_RX_MAN_BIT = 4;
  localparam int unsigned OP_TX_EN_BIT  = 3;
  localparam int unsigned OP_WU_BIT     = 2;
  localparam logic [7:0]  OP_RESET      = 8'h00;

  // Driver segments
  localparam int unsigned SEG_COUNT     = 8;
  localparam logic [7:0]  NORM_RESET    = 8'hFF;
  localparam logic [7:0]  AM_RESET      = 8'h00;

  // Operation control word as the host writes it
  typedef struct packed {
    logic       osc_en;
    logic       rx_en;
    logic       rx_chn;
    logic       rx_man;
    logic       tx_en;
    logic       low_power_detect_mode;
    logic [1:0] spare;
  } op_ctrl_t;

  // Transmit configuration bits
  typedef struct packed {
    logic single_drive;
    logic antenna_output_choice;
    logic modulation_type_select;
    logic keying_fast_decay;
    logic slow_up;
  } tx_cfg_t;

  // Receive configuration bits
  typedef struct packed {
    logic amd_mixer;
    logic external_demod_bypass;
    logic pm_manual_pick;
  } rx_cfg_t;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_DOWN  = 3'b001,
    MODE_READY = 3'b010,
    MODE_WAKE  = 3'b100
  } mode_t;

  // Depth calibration states
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_MEAS = 3'b010,
    CAL_WAIT = 3'b100
  } cal_state_t;

endpackage

// File: logic/wake_tick.sv
// Wake-up timer: periodic one-cycle tick while enabled.
// Assumes the enable is a level from the mode logic.
`timescale 1ns/1ns
module wake_tick import rf_mode_pkg::*; #(
  parameter int unsigned PERIOD = WAKE_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control and tick
  input  wire logic run_i,
  output logic      tick_o
);

  // Refused at elaboration: a period below two never wraps
  if (PERIOD < 2) begin
    $error("wake_tick: PERIOD must be at least 2");
  end

  localparam int unsigned CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] count;
  wire           at_end = (count == LAST);

  // Restarts from zero each time the mode is entered
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else begin
      count  <= at_end ? '0 : count + 1'b1;
      tick_o <= at_end;
    end
  end

endmodule
